// File: verilog/poe_port_event_flag_registers.sv
// Per-port event flag register bank with AHB-Lite slave and interrupt
//
// Design decision made here: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
module poe_port_event_flag_registers
  import event_flags_pkg::*;
#(
  parameter int overload_cycles = overload_cycles_def,
  parameter int limit_cycles = limit_cycles_def,
  parameter int cnt_w = 24
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Port state machine events, one bit per port, one-cycle pulses
  input wire logic [3:0] class_done,
  input wire logic [3:0] class_changed,
  input wire logic [3:0] detect_done,
  input wire logic [3:0] detect_changed,
  input wire logic [3:0] disconnect_evt,
  input wire logic [3:0] start_fault_evt,
  input wire logic [3:0] std_turn_on_error,
  input wire logic [3:0] port_off,
  // Port current status levels
  input wire logic [3:0] overload_active,
  input wire logic [3:0] at_current_limit,
  // Outputs
  output logic [3:0] overload_shutdown,
  output logic irq_n
);

  typedef struct packed {
    logic [31:0] rdata;
    logic pend_valid;
    logic pend_write;
    logic [7:0] pend_idx;
    logic [7:0] detect_flags;
    logic [7:0] fault_flags;
    logic [7:0] start_flags;
    logic [7:0] config_flags;
    logic [7:0] irq_status;
    logic [7:0] irq_mask;
    logic [num_ports*cnt_w-1:0] ovl_cnt;
    logic [num_ports*cnt_w-1:0] lim_cnt;
    logic [3:0] shutdown;
    logic irq_n;
  } state_t;

  state_t s_reg;
  state_t s_next;

  logic addr_phase;
  logic [7:0] addr_idx;
  logic read_cr_detect;
  logic read_cr_fault;
  logic read_cr_start;
  logic read_status;
  logic [3:0] cutoff_dis;
  logic [3:0] ovl_hit;
  logic [3:0] lim_hit;
  logic [7:0] detect_set;
  logic [7:0] fault_set;
  logic [7:0] start_set;
  logic [7:0] sum_now;
  logic [7:0] cr_clear;
  logic [31:0] ovl_lim;
  logic [31:0] half_lim;

  assign addr_phase = hsel & htrans[1] & hready;
  assign addr_idx = haddr[9:2];
  assign cutoff_dis = s_reg.config_flags[cfg_cutoff_dis_lsb +: 4];
  assign half_lim = 32'(limit_cycles / 2);
  assign ovl_lim = 32'(overload_cycles);

  // Clear-on-read acts in the data phase, after the contents are latched
  assign read_cr_detect = s_reg.pend_valid & ~s_reg.pend_write & (s_reg.pend_idx == detect_cr_idx);
  assign read_cr_fault = s_reg.pend_valid & ~s_reg.pend_write & (s_reg.pend_idx == fault_cr_idx);
  assign read_cr_start = s_reg.pend_valid & ~s_reg.pend_write & (s_reg.pend_idx == start_cr_idx);
  assign read_status = s_reg.pend_valid & ~s_reg.pend_write & (s_reg.pend_idx == irq_status_idx);

  // Per-port timers and event sources
  genvar p;
  generate
    for (p = 0; p < num_ports; p++) begin : g_port
      logic [cnt_w-1:0] oc;
      logic [cnt_w-1:0] lc;
      assign oc = s_reg.ovl_cnt[p*cnt_w +: cnt_w];
      assign lc = s_reg.lim_cnt[p*cnt_w +: cnt_w];
      // Cutoff disabled uses half the limit time as overload timeout
      assign ovl_hit[p] = overload_active[p] &
        (32'(oc) + 32'h1 == (cutoff_dis[p] ? half_lim : ovl_lim));
      assign lim_hit[p] = at_current_limit[p] & (32'(lc) + 32'h1 == 32'(limit_cycles));
      assign detect_set[4+p] = s_reg.config_flags[cfg_class_change_bit] ?
        class_changed[p] : class_done[p];
      assign detect_set[p] = s_reg.config_flags[cfg_detect_change_bit] ?
        detect_changed[p] : detect_done[p];
      assign fault_set[4+p] = disconnect_evt[p];
      assign fault_set[p] = ovl_hit[p];
      assign start_set[4+p] = lim_hit[p];
      assign start_set[p] = start_fault_evt[p] | std_turn_on_error[p];
    end
  endgenerate

  always_comb begin
    s_next = s_reg;
    // Bus address phase capture
    s_next.pend_valid = addr_phase;
    s_next.pend_write = hwrite;
    s_next.pend_idx = addr_idx;
    if (addr_phase && !hwrite) begin
      unique case (addr_idx)
        detect_idx, detect_cr_idx: s_next.rdata = {24'h0, s_reg.detect_flags};
        fault_idx, fault_cr_idx: s_next.rdata = {24'h0, s_reg.fault_flags};
        start_idx, start_cr_idx: s_next.rdata = {24'h0, s_reg.start_flags};
        config_idx: s_next.rdata = {24'h0, s_reg.config_flags};
        irq_status_idx: s_next.rdata = {24'h0, s_reg.irq_status};
        irq_mask_idx: s_next.rdata = {24'h0, s_reg.irq_mask};
        default: s_next.rdata = 32'h0;
      endcase
    end
    if (s_reg.pend_valid && s_reg.pend_write) begin
      if (s_reg.pend_idx == config_idx) s_next.config_flags = hwdata[7:0];
      if (s_reg.pend_idx == irq_mask_idx) s_next.irq_mask = hwdata[7:0];
    end

    // Counters: overload timer restarts on fault clear-on-read only with cutoff disabled
    for (int i = 0; i < num_ports; i++) begin
      if (!overload_active[i] || ovl_hit[i] || (read_cr_fault && cutoff_dis[i])) begin
        s_next.ovl_cnt[i*cnt_w +: cnt_w] = '0;
      end else begin
        s_next.ovl_cnt[i*cnt_w +: cnt_w] = s_reg.ovl_cnt[i*cnt_w +: cnt_w] + cnt_w'(1);
      end
      // Limit timer never touched by clear-on-read
      if (!at_current_limit[i] || lim_hit[i]) begin
        s_next.lim_cnt[i*cnt_w +: cnt_w] = '0;
      end else begin
        s_next.lim_cnt[i*cnt_w +: cnt_w] = s_reg.lim_cnt[i*cnt_w +: cnt_w] + cnt_w'(1);
      end
      if (port_off[i]) s_next.shutdown[i] = 1'b0;
      else if (ovl_hit[i] && !cutoff_dis[i]) s_next.shutdown[i] = 1'b1;
    end

    // Flags: clear first, then set so a coincident event survives
    if (read_cr_detect) s_next.detect_flags = flags_reset;
    if (read_cr_fault) s_next.fault_flags = flags_reset;
    if (read_cr_start) s_next.start_flags = flags_reset;
    s_next.fault_flags = s_next.fault_flags & ~{port_off, port_off};
    s_next.start_flags = s_next.start_flags & ~{port_off, port_off};
    s_next.detect_flags = s_next.detect_flags | detect_set;
    s_next.fault_flags = s_next.fault_flags | fault_set;
    s_next.start_flags = s_next.start_flags | start_set;

    // Summary bits follow the live flags; sticky status cleared by its own read
    sum_now = 8'h0;
    cr_clear = 8'h0;
    // A clearing read drops the summary bits its register feeds
    if (read_cr_detect) begin
      cr_clear[sum_detect_bit] = 1'b1;
      cr_clear[sum_class_bit] = 1'b1;
    end
    if (read_cr_fault) begin
      cr_clear[sum_fault_bit] = 1'b1;
      cr_clear[sum_ilim_bit] = 1'b1;
    end
    if (read_cr_start) begin
      cr_clear[sum_ilim_bit] = 1'b1;
      cr_clear[sum_start_bit] = 1'b1;
    end
    sum_now[sum_detect_bit] = |s_next.detect_flags[3:0];
    sum_now[sum_class_bit] = |s_next.detect_flags[7:4];
    sum_now[sum_fault_bit] = |s_next.fault_flags[7:4];
    sum_now[sum_ilim_bit] = |s_next.start_flags[7:4] | |s_next.fault_flags[3:0];
    sum_now[sum_start_bit] = |s_next.start_flags[3:0];
    // Flag registers hold the event, so a summary reasserts until its flags clear
    // Live flags set afterwards win, so a remaining or new event keeps its bit
    s_next.irq_status = ((read_status ? 8'h0 : s_reg.irq_status) & ~cr_clear) | sum_now;
    s_next.irq_n = ~|(s_next.irq_status & s_reg.irq_mask);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_reg <= '0;
      s_reg.irq_n <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign hrdata = s_reg.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign overload_shutdown = s_reg.shutdown;
  assign irq_n = s_reg.irq_n;

endmodule

// File: verilog/event_flags_pkg.sv
// Constants and types for the per-port event flag register bank
// Summary of operation
// - Class flags set per classification cycle, or only on class change when selected.
// - Detect flags set per detection cycle, or only on result change when selected.
// - Each nibble holds one bit per port, port 1 in the lowest bit.
// - Fault flags read at two codes; the second also clears them.
// - Start/limit flags read at two codes; the second also clears them.
// - Fault and start/limit flags of a port clear when that port switches off.
// - A clear-on-read of the flags driving the interrupt releases it.
// - Every set flag feeds its class summary bit in the interrupt register.
// - Fault upper nibble is disconnect, lower nibble is overload timer fault.
// - With cutoff disabled, overload flags but no switch-off, timeout half limit time.
// - Clear-on-read of fault flags resets overload counters, not limit counters.
// - Otherwise overload follows its normal timer; clear-on-read resets no counter.
// - Limit flags set when current held at limit longer than limit time.
// - Start flags set on start-time fault or class/detect error at standard turn-on.
// - Detection flags read at two codes; the second also clears them.
// - A masked event class does not drive the interrupt; flags still update.
package event_flags_pkg;

  localparam int num_ports = 4;

  // Register offsets are word indices taken from haddr[9:2] (byte address is index times four)
  localparam logic [7:0] detect_idx = 8'h04;
  localparam logic [7:0] detect_cr_idx = 8'h05;
  localparam logic [7:0] fault_idx = 8'h06;
  localparam logic [7:0] fault_cr_idx = 8'h07;
  localparam logic [7:0] start_idx = 8'h08;
  localparam logic [7:0] start_cr_idx = 8'h09;
  localparam logic [7:0] config_idx = 8'h10;
  localparam logic [7:0] irq_status_idx = 8'h11;
  localparam logic [7:0] irq_mask_idx = 8'h12;
  localparam logic [7:0] counter_cfg_idx = 8'h13;

  // Control register field positions
  localparam int cfg_class_change_bit = 0;
  localparam int cfg_detect_change_bit = 1;
  localparam int cfg_cutoff_dis_lsb = 4;

  // Interrupt summary bit positions (same layout for status and mask)
  localparam int sum_detect_bit = 3;
  localparam int sum_class_bit = 4;
  localparam int sum_fault_bit = 2;
  localparam int sum_ilim_bit = 5;
  localparam int sum_start_bit = 6;

  localparam logic [7:0] flags_reset = 8'h00;
  localparam logic [7:0] mask_reset = 8'h00;
  localparam logic [7:0] config_reset = 8'h00;

  // Times in microseconds at 20 MHz
  localparam int clk_mhz = 20;
  localparam int overload_time_us = 60000;
  localparam int current_limit_time_us = 60000;
  localparam int overload_cycles_def = overload_time_us * clk_mhz;
  localparam int limit_cycles_def = current_limit_time_us * clk_mhz;

endpackage

// File: test/ahb_host.sv
// Host model issuing single-word AHB-Lite transfers
`timescale 1ns/10ps
module ahb_host (
  // Clock and slave answer
  input wire logic clk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  // Master request
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [31:0] hwdata
);
  initial {hsel, haddr, htrans, hwrite, hwdata} = '0;
  // Index to byte address; no wait count assumed
  task automatic xfer(input logic [7:0] i, input logic w, input logic [31:0] wd,
      output logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {22'h0, i, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    d = hrdata;
  endtask
endmodule

// File: test/event_flags_props.sv
// Port-level checks for the event flag bank
`timescale 1ns/10ps
module event_flags_props (
  // Clock, reset, bus
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Port side
  input wire logic [3:0] port_off,
  input wire logic [3:0] overload_active,
  input wire logic [3:0] overload_shutdown,
  input wire logic irq_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire logic req = hsel && htrans[1];
  zero_wait_a: assert property (hreadyout) else $error("wait state");
  okay_resp_a: assert property (!hresp) else $error("error response");
  upper_zero_a: assert property (hrdata[31:8] == 24'h0) else $error("upper bits");
  data_stands_a: assert property (!$past(req) |-> $stable(hrdata))
    else $error("read data moved");
  off_clears_a: assert property ((overload_shutdown & $past(port_off)) == 4'h0)
    else $error("shutdown kept after off");
  off_only_a: assert property ((~overload_shutdown & $past(overload_shutdown)
    & ~$past(port_off)) == 4'h0) else $error("shutdown dropped");
  shut_cause_a: assert property ((overload_shutdown & ~$past(overload_shutdown)
    & ~$past(overload_active)) == 4'h0) else $error("shutdown without overload");
  irq_release_a: assert property ($rose(irq_n) |-> $past(req) || $past(req, 2)
    || $past(req, 3) || $past(port_off) != 4'h0) else $error("irq released alone");
  cover property ($fell(irq_n));
  cover property ($rose(irq_n));
  cover property ($rose(overload_shutdown[0]));
endmodule
bind poe_port_event_flag_registers event_flags_props u_props (.clk(clk), .sys_rst(sys_rst),
  .hsel(hsel), .htrans(htrans), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .port_off(port_off), .overload_active(overload_active),
  .overload_shutdown(overload_shutdown), .irq_n(irq_n));

// File: test/poe_port_event_flag_registers_test.sv
// Register-read bench for the event flag bank
`timescale 1ns/10ps
module poe_port_event_flag_registers_test import event_flags_pkg::*;;
  localparam int lim = 20;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  // Pulses: class, class chg, det, det chg, disc, start, std err, off
  logic [31:0] ev = '0;
  logic [7:0] lv = '0;
  wire logic hsel, hwrite, hreadyout, hresp, irq_n;
  wire logic [1:0] htrans;
  wire logic [31:0] haddr, hwdata, hrdata;
  wire logic [3:0] overload_shutdown;
  int bad_count = 0;
  int checks_done = 0;
  logic [31:0] d;
  ahb_host host (.clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata));
  poe_port_event_flag_registers #(.overload_cycles(lim), .limit_cycles(lim)) DUT (.clk(clk),
    .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .class_done(ev[3:0]), .class_changed(ev[7:4]),
    .detect_done(ev[11:8]), .detect_changed(ev[15:12]), .disconnect_evt(ev[19:16]),
    .start_fault_evt(ev[23:20]), .std_turn_on_error(ev[27:24]), .port_off(ev[31:28]),
    .overload_active(lv[3:0]), .at_current_limit(lv[7:4]),
    .overload_shutdown(overload_shutdown), .irq_n(irq_n));
  task automatic end_of_test();
    $display("mismatches %0d, checks %0d", bad_count, checks_done);
    if (bad_count == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h, want %h", $time, got, exp);
    end
  endtask
  task automatic chk(input logic [7:0] i, input logic [7:0] e);
    logic [31:0] r;
    host.xfer(i, 1'b0, 32'h0, r);
    cmp(r, {24'h0, e});
  endtask
  task automatic pulse(input logic [31:0] v);
    @(posedge clk);
    ev <= v;
    @(posedge clk);
    ev <= '0;
  endtask
  initial forever #25 clk = ~clk;
  // Whole sequence takes under two hundred cycles
  initial begin
    repeat (3000) @(posedge clk);
    bad_count++;
    end_of_test();
  end
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    for (logic [7:0] i = detect_idx; i <= start_cr_idx; i++) chk(i, flags_reset);
    chk(irq_mask_idx, mask_reset);
    chk(8'h3f, 8'h00);
    pulse(32'h0000_0104);
    chk(detect_idx, 8'h41);
    cmp({31'h0, irq_n}, 32'h1);
    chk(detect_cr_idx, 8'h41);
    chk(detect_idx, 8'h00);
    host.xfer(config_idx, 1'b1, 32'h23, d);
    pulse(32'h0000_2f1f);
    chk(detect_cr_idx, 8'h12);
    pulse(32'h0008_0000);
    chk(fault_idx, 8'h80);
    pulse(32'h8000_0000);
    chk(fault_idx, 8'h00);
    pulse(32'h0002_0000);
    // New event lands in the clearing read's data phase
    fork
      chk(fault_cr_idx, 8'h20);
      begin
        repeat (2) @(posedge clk);
        ev <= 32'h0001_0000;
        @(posedge clk);
        ev <= '0;
      end
    join
    chk(fault_idx, 8'h10);
    host.xfer(irq_mask_idx, 1'b1, 32'h04, d);
    repeat (3) @(posedge clk);
    cmp({31'h0, irq_n}, 32'h0);
    // Detect and class summaries went with the earlier clearing reads
    chk(irq_status_idx, 8'h04);
    chk(fault_cr_idx, 8'h10);
    @(posedge clk);
    cmp({31'h0, irq_n}, 32'h1);
    chk(irq_status_idx, 8'h00);
    repeat (2) @(posedge clk);
    cmp({31'h0, irq_n}, 32'h1);
    pulse(32'h0210_0000);
    lv <= 8'h40;
    repeat (lim + 10) @(posedge clk);
    lv <= 8'h00;
    // Host reads start causes here and decides inrush elsewhere
    chk(start_idx, 8'h43);
    chk(start_cr_idx, 8'h43);
    chk(start_idx, 8'h00);
    lv <= 8'h03;
    repeat (lim / 2 + 5) @(posedge clk);
    chk(fault_idx, 8'h02);
    cmp({28'h0, overload_shutdown}, 32'h0);
    repeat (10) @(posedge clk);
    chk(fault_idx, 8'h03);
    cmp({28'h0, overload_shutdown}, 32'h1);
    lv <= 8'h02;
    chk(fault_cr_idx, 8'h03);
    chk(fault_idx, 8'h00);
    repeat (lim / 2 + 2) @(posedge clk);
    chk(fault_idx, 8'h02);
    lv <= 8'h00;
    pulse(32'h3000_0000);
    chk(fault_idx, 8'h00);
    cmp({28'h0, overload_shutdown}, 32'h0);
    end_of_test();
  end
endmodule
